// File: rtl/wdt_control.sv
// How it works
// R1: Overflow after 2^18/2^20/2^22/2^24 gear or 2^11/2^13/2^15/2^17 low
// R2: Window 10: early clear interrupts, late clear clears
// R3: Window 11: clear only after three quarters
// R4: Fields locked while enable bit is one
// R5: Fields accepted in the write setting enable
// R6: Software disables: clear enable, then write B1
// R7: Control reads bit7 one, bit6 zero
// R8: One bit selects reset or interrupt on overflow
// R9: Overflow raises the selected request
// R10: Code 4E clears counter unless running out of window; others except B1 ignored
// R11: Window 00: clear accepted any time
// R12: B1 with enable zero stops, zeroes counter
// R13: Out-of-window clear sets window status; counting continues
`timescale 1ns/1ps
module wdt_control
  import wdt_pkg::*;
#(
  parameter int ADDR_W = 8
) (
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic [ADDR_W-1:0] awaddr,
  input wire logic [2:0] awprot,
  input wire logic awvalid,
  output logic awready,
  input wire logic [31:0] wdata,
  input wire logic [3:0] wstrb,
  input wire logic wvalid,
  output logic wready,
  output logic [1:0] bresp,
  output logic bvalid,
  input wire logic bready,
  input wire logic [ADDR_W-1:0] araddr,
  input wire logic [2:0] arprot,
  input wire logic arvalid,
  output logic arready,
  output logic [31:0] rdata,
  output logic [1:0] rresp,
  output logic rvalid,
  input wire logic rready,
  input wire logic gear_tick,
  input wire logic low_freq_clock,
  input wire logic slow_mode,
  output logic wdt_reset_req,
  output logic irq
);

  // ==========================================================================
  // Declarations
  ctrl_t ctrl_reg;
  logic running_reg;
  logic low_clock_prescale_sel;
  logic [IRQ_W-1:0] irq_status_reg;
  logic [IRQ_W-1:0] irq_mask_reg;
  logic [ADDR_W-1:0] waddr_reg;
  logic [31:0] wdata_reg;
  logic [3:0] wstrb_reg;
  logic aw_held_reg;
  logic w_held_reg;
  logic bvalid_reg;
  logic [1:0] bresp_reg;
  logic rvalid_reg;
  logic [31:0] rdata_reg;
  logic [1:0] rresp_reg;
  logic wr_fire;
  logic wr_low;
  logic ctrl_wr;
  logic code_wr;
  logic clear_cmd;
  logic disable_cmd;
  logic in_window;
  logic counter_clear;
  logic win_evt;
  logic ovf_evt;
  logic [COUNTER_W-1:0] count;
  logic overflow;
  logic [7:0] ctrl_read;

  function automatic logic mapped(input logic [ADDR_W-1:0] a);
    return a == ADDR_W'(OFF_CONTROL) || a == ADDR_W'(OFF_CODE) ||
           a == ADDR_W'(OFF_COUNT) || a == ADDR_W'(OFF_IRQ_STATUS) ||
           a == ADDR_W'(OFF_IRQ_MASK) || a == ADDR_W'(OFF_CONFIG);
  endfunction

  // ==========================================================================
  // AXI4-Lite write channel: address and data taken in either order
  assign awready = !aw_held_reg && !bvalid_reg;
  assign wready = !w_held_reg && !bvalid_reg;
  assign wr_fire = aw_held_reg && w_held_reg && !bvalid_reg;
  assign bvalid = bvalid_reg;
  assign bresp = bresp_reg;

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      aw_held_reg <= 1'b0;
      waddr_reg <= '0;
    end else if (awvalid && awready) begin
      aw_held_reg <= 1'b1;
      waddr_reg <= awaddr;
    end else if (wr_fire) begin
      aw_held_reg <= 1'b0;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      w_held_reg <= 1'b0;
      wdata_reg <= '0;
      wstrb_reg <= '0;
    end else if (wvalid && wready) begin
      w_held_reg <= 1'b1;
      wdata_reg <= wdata;
      wstrb_reg <= wstrb;
    end else if (wr_fire) begin
      w_held_reg <= 1'b0;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      bvalid_reg <= 1'b0;
      bresp_reg <= RESP_OKAY;
    end else if (wr_fire) begin
      bvalid_reg <= 1'b1;
      bresp_reg <= mapped(waddr_reg) ? RESP_OKAY : RESP_SLVERR;
    end else if (bready) begin
      bvalid_reg <= 1'b0;
    end
  end

  // Only the low byte lane carries register bits
  assign wr_low = wr_fire && wstrb_reg[0];
  assign ctrl_wr = wr_low && waddr_reg == ADDR_W'(OFF_CONTROL);
  assign code_wr = wr_low && waddr_reg == ADDR_W'(OFF_CODE);

  // ==========================================================================
  // Control register
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      ctrl_reg.enable <= CTRL_EN_RST;
    end else if (ctrl_wr) begin
      ctrl_reg.enable <= wdata_reg[CTRL_EN_BIT];
    end
  end

  // Fields move only while the enable bit is clear; a write that sets it
  // from zero still lands because the lock looks at the stored bit
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      ctrl_reg.clear_window_sel <= CTRL_CWIN_RST;
      ctrl_reg.overflow_time_sel <= CTRL_OTIME_RST;
      ctrl_reg.overflow_signal_sel <= CTRL_OSEL_RST;
    end else if (ctrl_wr && !ctrl_reg.enable) begin // R4 R5
      ctrl_reg.clear_window_sel <= wdata_reg[CTRL_CWIN_LSB+:2];
      ctrl_reg.overflow_time_sel <= wdata_reg[CTRL_OTIME_LSB+:2];
      ctrl_reg.overflow_signal_sel <= wdata_reg[CTRL_OSEL_BIT]; // R8
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      low_clock_prescale_sel <= CFG_PRESCALE_RST;
    end else if (wr_low && waddr_reg == ADDR_W'(OFF_CONFIG)) begin
      low_clock_prescale_sel <= wdata_reg[CFG_PRESCALE_BIT];
    end
  end

  // ==========================================================================
  // Control codes and operating state
  assign clear_cmd = code_wr && wdata_reg[7:0] == CODE_CLEAR; // R10
  assign disable_cmd = code_wr && wdata_reg[7:0] == CODE_DISABLE && !ctrl_reg.enable; // R12 R6

  always_comb begin
    case (ctrl_reg.clear_window_sel)
      CWIN_HALF: in_window = count[COUNTER_W-1]; // R2
      CWIN_3QTR: in_window = &count[COUNTER_W-1-:2]; // R3
      default: in_window = 1'b1; // R11
    endcase
  end

  // Stopping wins over a clear or an overflow landing in the same cycle
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      running_reg <= CTRL_EN_RST;
    end else if (disable_cmd) begin
      running_reg <= 1'b0; // R12
    end else if (ctrl_wr && wdata_reg[CTRL_EN_BIT]) begin
      running_reg <= 1'b1;
    end
  end

  assign counter_clear = disable_cmd || (clear_cmd && (in_window || !running_reg)); // R10 R12
  assign win_evt = clear_cmd && running_reg && !in_window; // R13 R2 R3
  assign ovf_evt = overflow && running_reg && !disable_cmd;

  wdt_counter #(
    .CNT_W(COUNTER_W),
    .PRE_W(PRESCALE_W)
  ) u_counter (
    .aclk(aclk),
    .aresetn(aresetn),
    .run(running_reg),
    .clear(counter_clear),
    .src_tick(low_clock_prescale_sel || slow_mode ? low_freq_clock : gear_tick), // R1
    .use_low(low_clock_prescale_sel || slow_mode),
    .time_sel(ctrl_reg.overflow_time_sel),
    .count_reg(count),
    .overflow_reg(overflow)
  );

  // ==========================================================================
  // Overflow requests
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      wdt_reset_req <= 1'b0;
    end else begin
      wdt_reset_req <= ovf_evt && ctrl_reg.overflow_signal_sel == OSEL_RESET; // R9
    end
  end

  // Set wins over a write-one clear in the same cycle
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      irq_status_reg <= '0;
    end else begin
      irq_status_reg <= (irq_status_reg &
        ~((wr_low && waddr_reg == ADDR_W'(OFF_IRQ_STATUS)) ? wdata_reg[IRQ_W-1:0] : '0)) |
        {ovf_evt && ctrl_reg.overflow_signal_sel == OSEL_IRQ, win_evt}; // R9 R13
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      irq_mask_reg <= '0;
    end else if (wr_low && waddr_reg == ADDR_W'(OFF_IRQ_MASK)) begin
      irq_mask_reg <= wdata_reg[IRQ_W-1:0];
    end
  end

  assign irq = |(irq_status_reg & irq_mask_reg);

  // ==========================================================================
  // AXI4-Lite read channel
  assign ctrl_read = {CTRL_TOP_BITS, ctrl_reg}; // R7
  assign arready = !rvalid_reg;
  assign rvalid = rvalid_reg;
  assign rdata = rdata_reg;
  assign rresp = rresp_reg;

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      rvalid_reg <= 1'b0;
      rdata_reg <= '0;
      rresp_reg <= RESP_OKAY;
    end else if (arvalid && arready) begin
      rvalid_reg <= 1'b1;
      rresp_reg <= mapped(araddr) ? RESP_OKAY : RESP_SLVERR;
      // Code register is write-only and reads as zero
      case (araddr)
        ADDR_W'(OFF_CONTROL): rdata_reg <= {24'h000000, ctrl_read};
        ADDR_W'(OFF_COUNT): rdata_reg <= {24'h000000, count};
        ADDR_W'(OFF_IRQ_STATUS): rdata_reg <= {30'h00000000, irq_status_reg};
        ADDR_W'(OFF_IRQ_MASK): rdata_reg <= {30'h00000000, irq_mask_reg};
        ADDR_W'(OFF_CONFIG): rdata_reg <= {29'h00000000, running_reg, slow_mode,
                                          low_clock_prescale_sel};
        default: rdata_reg <= '0;
      endcase
    end else if (rready) begin
      rvalid_reg <= 1'b0;
    end
  end

endmodule // wdt_control

// File: rtl/wdt_pkg.sv
package wdt_pkg;

  // ==========================================================================
  // Register byte offsets (one aligned 32-bit word each)
  localparam logic [7:0] OFF_CONTROL = 8'h00;
  localparam logic [7:0] OFF_CODE = 8'h04;
  localparam logic [7:0] OFF_COUNT = 8'h08;
  localparam logic [7:0] OFF_IRQ_STATUS = 8'h0C;
  localparam logic [7:0] OFF_IRQ_MASK = 8'h10;
  localparam logic [7:0] OFF_CONFIG = 8'h14;

  // ==========================================================================
  // Control register fields
  localparam int CTRL_EN_BIT = 0;
  localparam int CTRL_OSEL_BIT = 1;
  localparam int CTRL_OTIME_LSB = 2;
  localparam int CTRL_CWIN_LSB = 4;
  localparam logic [1:0] CTRL_TOP_BITS = 2'h2;
  localparam logic CTRL_EN_RST = 1'h1;
  localparam logic CTRL_OSEL_RST = 1'h1;
  localparam logic [1:0] CTRL_OTIME_RST = 2'h0;
  localparam logic [1:0] CTRL_CWIN_RST = 2'h0;

  // Overflow-signal select values
  localparam logic OSEL_IRQ = 1'h0;
  localparam logic OSEL_RESET = 1'h1;

  // Clear-window select values
  localparam logic [1:0] CWIN_ANY = 2'h0;
  localparam logic [1:0] CWIN_HALF = 2'h2;
  localparam logic [1:0] CWIN_3QTR = 2'h3;

  // ==========================================================================
  // Control codes
  localparam logic [7:0] CODE_CLEAR = 8'h4E;
  localparam logic [7:0] CODE_DISABLE = 8'hB1;

  // ==========================================================================
  // Interrupt status bits, config bits
  localparam int IRQ_WIN_BIT = 0;
  localparam int IRQ_OVF_BIT = 1;
  localparam int IRQ_W = 2;
  localparam int CFG_PRESCALE_BIT = 0;
  localparam logic CFG_PRESCALE_RST = 1'h0;

  // ==========================================================================
  // Overflow times as powers of two of source clocks, per overflow-time select
  localparam int OVF_EXP_GEAR_0 = 18;
  localparam int OVF_EXP_GEAR_1 = 20;
  localparam int OVF_EXP_GEAR_2 = 22;
  localparam int OVF_EXP_GEAR_3 = 24;
  localparam int OVF_EXP_LOW_0 = 11;
  localparam int OVF_EXP_LOW_1 = 13;
  localparam int OVF_EXP_LOW_2 = 15;
  localparam int OVF_EXP_LOW_3 = 17;
  localparam int COUNTER_W = 8;
  localparam int PRESCALE_W = 16;

  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

  typedef struct packed {
    logic [1:0] clear_window_sel;
    logic [1:0] overflow_time_sel;
    logic overflow_signal_sel;
    logic enable;
  } ctrl_t;

  // Prescaler stages in front of the 8-bit counter
  function automatic logic [4:0] prescale_exp(input logic [1:0] sel, input logic use_low);
    int e;
    case (sel)
      2'h0: e = use_low ? OVF_EXP_LOW_0 : OVF_EXP_GEAR_0;
      2'h1: e = use_low ? OVF_EXP_LOW_1 : OVF_EXP_GEAR_1;
      2'h2: e = use_low ? OVF_EXP_LOW_2 : OVF_EXP_GEAR_2;
      default: e = use_low ? OVF_EXP_LOW_3 : OVF_EXP_GEAR_3;
    endcase
    return 5'(e - COUNTER_W);
  endfunction

endpackage

// File: rtl/wdt_counter.sv
`timescale 1ns/1ps
module wdt_counter
  import wdt_pkg::*;
#(
  parameter int CNT_W = COUNTER_W,
  parameter int PRE_W = PRESCALE_W
) (
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic run,
  input wire logic clear,
  input wire logic src_tick,
  input wire logic use_low,
  input wire logic [1:0] time_sel,
  output logic [CNT_W-1:0] count_reg,
  output logic overflow_reg
);

  logic [PRE_W-1:0] prescale_reg;
  logic [PRE_W-1:0] low_mask;
  logic presc_done;
  logic step;

  // Counter steps once per 2^exp source ticks, so overflow lands at 2^(exp+8)
  assign low_mask = (PRE_W'(1) << prescale_exp(time_sel, use_low)) - PRE_W'(1);
  assign presc_done = &(prescale_reg | ~low_mask);
  assign step = run && src_tick && presc_done;

  // ==========================================================================
  // Prescaler
  always_ff @(posedge aclk) begin
    if (!aresetn || clear) begin
      prescale_reg <= '0;
    end else if (run && src_tick) begin
      prescale_reg <= presc_done ? '0 : prescale_reg + PRE_W'(1);
    end
  end

  // ==========================================================================
  // 8-bit up counter, wraps and keeps counting after overflow
  always_ff @(posedge aclk) begin
    if (!aresetn || clear) begin
      count_reg <= '0;
    end else if (step) begin
      count_reg <= count_reg + CNT_W'(1); // R1
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      overflow_reg <= 1'b0;
    end else begin
      overflow_reg <= step && (&count_reg) && !clear; // R1
    end
  end

endmodule // wdt_counter

// File: verification/wdt_control_chk.sv
`timescale 1ns/1ps
module wdt_control_chk
  import wdt_pkg::*;
#(
  parameter int ADDR_W = 8
) (
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic awvalid,
  input wire logic awready,
  input wire logic wvalid,
  input wire logic wready,
  input wire logic [1:0] bresp,
  input wire logic bvalid,
  input wire logic bready,
  input wire logic [ADDR_W-1:0] araddr,
  input wire logic arvalid,
  input wire logic arready,
  input wire logic [31:0] rdata,
  input wire logic [1:0] rresp,
  input wire logic rvalid,
  input wire logic rready,
  input wire logic wdt_reset_req,
  input wire logic irq
);
  // ========
  // Address of the read in flight
  logic [ADDR_W-1:0] rd_addr_reg;
  always_ff @(posedge aclk) begin
    if (!aresetn) rd_addr_reg <= '0;
    else if (arvalid && arready) rd_addr_reg <= araddr;
  end
  default clocking @(posedge aclk); endclocking
  default disable iff (!aresetn);
  // ========
  // Assertions
  a_bvalid_holds: assert property (bvalid && !bready |=> bvalid && $stable(bresp))
    else $error("write response dropped early");
  a_rvalid_holds: assert property (rvalid && !rready |=> rvalid && $stable(rdata))
    else $error("read data dropped early");
  a_busy_refuse: assert property (bvalid |-> !awready && !wready)
    else $error("write taken while response pending");
  a_read_refuse: assert property (rvalid |-> !arready)
    else $error("read taken while data pending");
  a_read_latency: assert property (arvalid && arready |=> rvalid)
    else $error("read answer late");
  a_write_latency: assert property (awvalid && awready && wvalid && wready |-> ##2 bvalid)
    else $error("write answer late");
  a_ctrl_fixed: assert property (rvalid && rd_addr_reg == OFF_CONTROL |-> rdata[7:6] == 2'h2)
    else $error("control fixed bits wrong");
  a_unmapped_err: assert property (rvalid && rd_addr_reg > OFF_CONFIG |-> rresp == RESP_SLVERR)
    else $error("unmapped read not refused");
  a_reset_pulse: assert property (wdt_reset_req |=> !wdt_reset_req)
    else $error("reset request longer than a pulse");
  c_reset_req: cover property (wdt_reset_req);
  c_irq_rise: cover property ($rose(irq));
  c_slverr: cover property (rvalid && rresp == RESP_SLVERR);
endmodule // wdt_control_chk

bind wdt_control wdt_control_chk #(.ADDR_W(ADDR_W)) u_chk (.aclk, .aresetn, .awvalid,
  .awready, .wvalid, .wready, .bresp, .bvalid, .bready, .araddr, .arvalid, .arready,
  .rdata, .rresp, .rvalid, .rready, .wdt_reset_req, .irq);

// File: verification/windowed_watchdog_config_tb.sv
`timescale 1ns/1ps
module windowed_watchdog_config_tb
  import wdt_pkg::*;
;
  logic aclk = 0, aresetn = 0;
  logic [7:0] awaddr = 0, araddr = 0;
  logic [31:0] wdata = 0, rdata;
  logic [3:0] wstrb = 0;
  logic awvalid = 0, wvalid = 0, bready = 0, arvalid = 0, rready = 0;
  logic awready, wready, bvalid, arready, rvalid, wdt_reset_req, irq;
  logic [1:0] bresp, rresp;
  logic slow_mode = 1, gear_tick = 1, low_freq_clock = 1;
  int fails = 0, compares = 0;
  always #50 aclk = ~aclk;
  // Source ticks every cycle in slow mode: one overflow is 2048 cycles
  wdt_control u_dut (.aclk, .aresetn, .awaddr, .awprot(3'h0), .awvalid, .awready,
    .wdata, .wstrb, .wvalid, .wready, .bresp, .bvalid, .bready, .araddr,
    .arprot(3'h0), .arvalid, .arready, .rdata, .rresp, .rvalid, .rready,
    .gear_tick, .low_freq_clock, .slow_mode, .wdt_reset_req, .irq);
  // ========
  // Shared tasks
  task automatic tally_and_finish;
    $display("mismatches %0d compares %0d", fails, compares);
    if (fails == 0 && compares > 0)
      $display("Testbench passed");
    else
      $display("Testbench failed");
    $finish;
  endtask
  task automatic hang;
    fails++;
    tally_and_finish;
  endtask
  task automatic chk(input string n, input logic [31:0] e, input logic [31:0] g);
    compares++;
    if (g !== e) begin
      fails++;
      $display("wrong value %s expected %h seen %h", n, e, g);
    end
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d, input logic [1:0] er);
    logic ta, tw, tb;
    @(posedge aclk);
    awaddr <= a; wdata <= d; wstrb <= 4'hF;
    awvalid <= 1'b1; wvalid <= 1'b1; bready <= 1'b1;
    for (int n = 0; n < 20; n++) begin
      // Sampled mid-cycle so the handshake edge is never raced
      @(negedge aclk);
      ta = awvalid && awready; tw = wvalid && wready; tb = bvalid;
      @(posedge aclk);
      if (ta) awvalid <= 1'b0;
      if (tw) wvalid <= 1'b0;
      if (tb) begin
        bready <= 1'b0;
        chk("bresp", {30'h0, er}, {30'h0, bresp});
        return;
      end
    end
    hang;
  endtask
  task automatic rd(input logic [7:0] a, output logic [31:0] d, output logic [1:0] r);
    logic ta, tr;
    @(posedge aclk);
    araddr <= a; arvalid <= 1'b1; rready <= 1'b1;
    for (int n = 0; n < 20; n++) begin
      @(negedge aclk);
      ta = arvalid && arready; tr = rvalid; d = rdata; r = rresp;
      @(posedge aclk);
      if (ta) arvalid <= 1'b0;
      if (tr) begin
        rready <= 1'b0;
        return;
      end
    end
    hang;
  endtask
  task automatic rchk(input string n, input logic [7:0] a, input logic [31:0] e);
    logic [31:0] d;
    logic [1:0] r;
    rd(a, d, r);
    chk(n, e, d);
  endtask
  task automatic wait_out(input bit rst);
    for (int n = 0; n < 2400; n++) begin
      @(negedge aclk);
      if ((rst ? wdt_reset_req : irq) === 1'b1) return;
    end
    hang;
  endtask
  // ========
  // Scenarios
  task automatic t_lock_disable;
    rchk("control", OFF_CONTROL, 32'h83);
    wr(OFF_CONTROL, 32'h3C, RESP_OKAY);
    rchk("control", OFF_CONTROL, 32'h82);
    rchk("config", OFF_CONFIG, 32'h6);
    wr(OFF_CODE, {24'h0, CODE_DISABLE}, RESP_OKAY);
    rchk("config", OFF_CONFIG, 32'h2);
    rchk("count", OFF_COUNT, 32'h0);
  endtask
  task automatic t_half_window;
    logic [31:0] d;
    logic [1:0] r;
    int n;
    wr(OFF_CONTROL, 32'h21, RESP_OKAY);
    rchk("control", OFF_CONTROL, 32'hA1);
    wr(OFF_IRQ_MASK, 32'h3, RESP_OKAY);
    wr(OFF_CODE, {24'h0, CODE_CLEAR}, RESP_OKAY);
    chk("irq", 32'h1, {31'h0, irq});
    rchk("status", OFF_IRQ_STATUS, 32'h1);
    wr(OFF_IRQ_STATUS, 32'h1, RESP_OKAY);
    chk("irq", 32'h0, {31'h0, irq});
    for (n = 0; n < 600; n++) begin
      rd(OFF_COUNT, d, r);
      if (d >= 32'd128) break;
    end
    if (n == 600) hang;
    wr(OFF_CODE, 32'h55, RESP_OKAY);
    rd(OFF_COUNT, d, r);
    chk("count kept", 32'h1, {31'h0, d >= 32'd128});
    wr(OFF_CODE, {24'h0, CODE_CLEAR}, RESP_OKAY);
    rd(OFF_COUNT, d, r);
    chk("count cleared", 32'h1, {31'h0, d < 32'd2});
    chk("irq", 32'h0, {31'h0, irq});
    wait_out(1'b0);
    rchk("status", OFF_IRQ_STATUS, 32'h2);
  endtask
  task automatic t_quarter_reset;
    wr(OFF_IRQ_STATUS, 32'h3, RESP_OKAY);
    wr(OFF_CONTROL, 32'h20, RESP_OKAY);
    wr(OFF_CODE, {24'h0, CODE_DISABLE}, RESP_OKAY);
    wr(OFF_CONTROL, 32'h33, RESP_OKAY);
    rchk("control", OFF_CONTROL, 32'hB3);
    wr(OFF_CODE, {24'h0, CODE_CLEAR}, RESP_OKAY);
    rchk("status", OFF_IRQ_STATUS, 32'h1);
    wait_out(1'b1);
    rchk("status", OFF_IRQ_STATUS, 32'h1);
  endtask
  task automatic t_time_source;
    logic [31:0] d;
    logic [1:0] r;
    int n;
    wr(OFF_IRQ_STATUS, 32'h3, RESP_OKAY);
    wr(OFF_CONTROL, 32'h00, RESP_OKAY);
    wr(OFF_CODE, {24'h0, CODE_DISABLE}, RESP_OKAY);
    wr(OFF_CONTROL, 32'h09, RESP_OKAY);
    wr(OFF_CODE, {24'h0, CODE_CLEAR}, RESP_OKAY);
    rchk("status", OFF_IRQ_STATUS, 32'h0);
    rd(OFF_COUNT, d, r);
    chk("count cleared", 32'h1, {31'h0, d < 32'd2});
    // Overflow lands 2^15 low ticks after the clear; the reads above eat a few
    for (n = 0; n < 32800; n++) begin
      @(negedge aclk);
      if (irq === 1'b1) break;
    end
    if (n == 32800) hang;
    chk("overflow cycles", 32'h1, {31'h0, n >= 32752 && n <= 32768});
    // Normal mode without prescale option follows the gear ticks only
    @(posedge aclk);
    slow_mode <= 1'b0;
    gear_tick <= 1'b0;
    wr(OFF_CODE, {24'h0, CODE_CLEAR}, RESP_OKAY);
    repeat (300) @(posedge aclk);
    rchk("count gear", OFF_COUNT, 32'h0);
    wr(OFF_CONFIG, 32'h1, RESP_OKAY);
    repeat (300) @(posedge aclk);
    rd(OFF_COUNT, d, r);
    chk("count low", 32'h1, {31'h0, d >= 32'd2});
  endtask
  task automatic t_unmapped;
    logic [31:0] d;
    logic [1:0] r;
    wr(8'h40, 32'h1, RESP_SLVERR);
    rd(8'h40, d, r);
    chk("rresp", {30'h0, RESP_SLVERR}, {30'h0, r});
    chk("rdata", 32'h0, d);
  endtask
  initial begin
    repeat (20) @(posedge aclk);
    aresetn <= 1'b1;
    t_lock_disable;
    t_half_window;
    t_quarter_reset;
    t_time_source;
    t_unmapped;
    tally_and_finish;
  end
endmodule // windowed_watchdog_config_tb
